// file: spb_chk_assertions.sv
// Checker for the serial port core, watching only the ports of spb_core.
// Assumes the register map header and one clock domain on clock_i.
`timescale 1ns/1ps
`include "spb_map.vh"
module spb_chk (
   input wire clock_i,
   input wire rst_i,
   input wire [3:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [15:0] reg_rdata_o,
   input wire irq_o,
   input wire sclk_i,
   input wire sclk_o,
   input wire sclk_oe_o,
   input wire sdo_o,
   input wire sdo_oe_o,
   input wire sdi_i,
   input wire ss_n_i
);
   // ****************
   // Shadow state
   // ****************
   reg sh_en;
   reg [15:0] sh_c1;
   reg [1:0] sh_mask;
   reg [4:0] rises;
   reg [3:0] lows;
   wire oe_exp = sh_en & sh_c1[`SPB_C1_MSTR] & ~sh_c1[`SPB_C1_CKDIS];
   wire do_exp = sh_en & sh_c1[`SPB_C1_MSTR] & ~sh_c1[`SPB_C1_DODIS];
   // Copies of written control, taken on the same edge as the core takes them
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sh_en <= 1'b0;
         sh_c1 <= 16'h0000;
         sh_mask <= 2'h0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == `SPB_ADDR_STAT)
            sh_en <= reg_wdata_i[`SPB_ST_EN];
         if (reg_addr_i == `SPB_ADDR_CON1)
            sh_c1 <= reg_wdata_i;
         if (reg_addr_i == `SPB_ADDR_IRQM)
            sh_mask <= reg_wdata_i[1:0];
      end
   end
   // A low run of five marks a word gap; a low half inside a word is only four
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rises <= 5'h00;
         lows <= 4'h0;
      end else begin
         lows <= sclk_o ? 4'h0 : ((lows == 4'hf) ? lows : lows + 4'h1);
         if (lows == 4'h5)
            rises <= {4'h0, sclk_o}; // A gap of exactly five lows ends on the next word's first rise
         else if (sclk_o && (lows != 4'h0))
            rises <= rises + 5'h01;
      end
   end
   // ****************
   // Assertions
   // ****************
   default clocking chk_cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   sequence s_off;
      !sh_en [*2];
   endsequence
   sequence s_high_half;
      sclk_o [*3] ##1 !sclk_o;
   endsequence
   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property ($past(reg_rd_i) && ($past(reg_addr_i) > 4'h4) |-> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   a_irq_masked: assert property (sh_mask == 2'h0 |-> !irq_o)
      else $error("interrupt high while masked");
   a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(reg_wr_i))
      else $error("interrupt fell without a register write");
   a_clk_oe: assert property ($stable(oe_exp) |-> sclk_oe_o == oe_exp)
      else $error("clock pin enable wrong");
   a_sdo_oe: assert property (sh_c1[`SPB_C1_MSTR] && $stable(do_exp) |-> sdo_oe_o == do_exp)
      else $error("data out enable wrong");
   a_off_quiet: assert property (s_off |-> !sclk_o && !sdo_oe_o)
      else $error("port active while disabled");
   a_sclk_half: assert property ($rose(sclk_o) |=> s_high_half)
      else $error("clock high half not four cycles");
   a_sdo_hold: assert property ($rose(sclk_o) |-> $stable(sdo_o) [*4])
      else $error("data out moved outside a trail edge");
   a_word_bits: assert property ((lows == 4'h5) && (rises != 5'h00) |->
      rises == (sh_c1[`SPB_C1_WIDTH] ? 5'h10 : 5'h08))
      else $error("clock edges per word wrong");
endmodule
bind spb_core spb_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .irq_o(irq_o), .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .sdo_o(sdo_o),
   .sdo_oe_o(sdo_oe_o), .sdi_i(sdi_i), .ss_n_i(ss_n_i));

// file: spb_core.v
// Serial port with transmit and receive FIFOs, buffer interrupt selector and control word one.
// Assumes a plain register port on clock_i and an external peer on the serial pins.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`include "spb_map.vh"
module spb_core (
   input wire clock_i,
   input wire rst_i,
   input wire [3:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output wire [15:0] reg_rdata_o,
   output wire irq_o,
   input wire sclk_i,
   output wire sclk_o,
   output wire sclk_oe_o,
   output wire sdo_o,
   output wire sdo_oe_o,
   input wire sdi_i,
   input wire ss_n_i
);
   // ****************************************
   // Registers and state
   // ****************************************
   reg en_reg, enh_reg, ovf_reg;
   reg [2:0] sel_reg;
   reg ckdis_reg, dodis_reg, width_reg, smp_reg, mstr_reg;
   reg [1:0] irqs_reg, irqm_reg;
   reg [15:0] rdata_reg;
   reg data_sel_reg;
   reg [2:0] tx_cnt_reg, rx_cnt_reg;
   reg [1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
   reg tx_ok_reg;
   reg busy_reg;
   reg [4:0] bit_cnt_reg;
   reg [2:0] div_reg;
   reg sclk_reg;
   reg [15:0] tx_sh_reg, rx_sh_reg;
   reg [2:0] sync1_reg, sync2_reg;
   reg sclk_prev_reg;
   reg lvl_prev_reg;
   wire [15:0] tx_q, rx_q;

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Pins are asynchronous to clock_i; only the second stage is used
   // Clock bit resets to its idle low level so no false edge follows reset
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_reg <= 3'h6;
         sync2_reg <= 3'h6;
         sclk_prev_reg <= 1'b0;
      end else begin
         sync1_reg <= {ss_n_i, sdi_i, sclk_i};
         sync2_reg <= sync1_reg;
         sclk_prev_reg <= sync2_reg[0];
      end
   end

   wire sclk_s = sync2_reg[0];
   wire sdi_s = sync2_reg[1];
   wire ss_s = sync2_reg[2];

   // ****************************************
   // Decode and buffer levels
   // ****************************************
   wire wr_stat = reg_wr_i && (reg_addr_i == `SPB_ADDR_STAT);
   wire wr_con1 = reg_wr_i && (reg_addr_i == `SPB_ADDR_CON1);
   wire wr_data = reg_wr_i && (reg_addr_i == `SPB_ADDR_DATA);
   wire wr_irqs = reg_wr_i && (reg_addr_i == `SPB_ADDR_IRQS);
   wire wr_irqm = reg_wr_i && (reg_addr_i == `SPB_ADDR_IRQM);
   wire rd_data = reg_rd_i && (reg_addr_i == `SPB_ADDR_DATA);

   // Legacy mode behaves as a single-word buffer
   wire [2:0] depth_c = enh_reg ? `SPB_DEPTH_ENH : `SPB_DEPTH_LEG;
   wire tx_full = (tx_cnt_reg >= depth_c); // see R2
   wire rx_full = (rx_cnt_reg >= depth_c); // see R6
   wire rx_empty = (rx_cnt_reg == 3'h0);
   wire tx_push = wr_data && !tx_full;
   wire rx_pop = rd_data && !rx_empty;

   // ****************************************
   // Shift engine timing
   // ****************************************
   // Master ticks come from the divider, slave edges from the sampled pin clock
   wire [4:0] last_bit = width_reg ? 5'd15 : 5'd7; // see R11
   wire m_tick = mstr_reg && busy_reg && (div_reg == (`SPB_SCLK_HALF - 1));
   wire s_act = !mstr_reg && !ss_s;
   wire lead_c = mstr_reg ? (m_tick && !sclk_reg) : (s_act && sclk_s && !sclk_prev_reg);
   wire trail_c = mstr_reg ? (m_tick && sclk_reg) : (s_act && !sclk_s && sclk_prev_reg);
   wire done_c = trail_c && (bit_cnt_reg == last_bit);
   wire smp_eff = mstr_reg && smp_reg;
   wire tx_avail = (tx_cnt_reg != 3'h0) && tx_ok_reg;
   wire load_c = en_reg && !busy_reg && tx_avail &&
                 (mstr_reg || ((bit_cnt_reg == 5'd0) && !lead_c && !trail_c));
   wire [15:0] rx_word_raw = smp_eff ? {rx_sh_reg[14:0], sdi_s} : rx_sh_reg;
   wire [15:0] rx_word = width_reg ? rx_word_raw : {8'h00, rx_word_raw[7:0]};
   wire rx_push = done_c && !rx_full; // see R13
   wire ovf_set = done_c && rx_full; // see R13

   // Occupancy after this cycle, used by the slot conditions
   wire [2:0] tx_next = tx_cnt_reg + {2'b00, tx_push} - {2'b00, load_c};
   wire [2:0] rx_next = rx_cnt_reg + {2'b00, rx_push} - {2'b00, rx_pop};

   // ****************************************
   // FIFO storage
   // ****************************************
   spb_mem u_tx_mem (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .wr_en_i(tx_push),
      .wr_addr_i(tx_wp_reg),
      .wr_data_i(reg_wdata_i),
      .rd_addr_i(tx_rp_reg),
      .rd_data_o(tx_q)
   );

   spb_mem u_rx_mem (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .wr_en_i(rx_push),
      .wr_addr_i(rx_wp_reg),
      .wr_data_i(rx_word),
      .rd_addr_i(rx_rp_reg),
      .rd_data_o(rx_q)
   );

   // Pointer and count bookkeeping; tx_ok waits for the registered read to settle
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         tx_cnt_reg <= 3'h0;
         rx_cnt_reg <= 3'h0;
         tx_wp_reg <= 2'h0;
         tx_rp_reg <= 2'h0;
         rx_wp_reg <= 2'h0;
         rx_rp_reg <= 2'h0;
         tx_ok_reg <= 1'b0;
      end else begin
         tx_cnt_reg <= tx_next;
         rx_cnt_reg <= rx_next;
         tx_ok_reg <= (tx_cnt_reg != 3'h0) && !load_c;
         if (tx_push) begin
            tx_wp_reg <= tx_wp_reg + 2'h1;
         end
         if (load_c) begin
            tx_rp_reg <= tx_rp_reg + 2'h1;
         end
         if (rx_push) begin
            rx_wp_reg <= rx_wp_reg + 2'h1;
         end
         if (rx_pop) begin
            rx_rp_reg <= rx_rp_reg + 2'h1;
         end
      end
   end

   // ****************************************
   // Shifter
   // ****************************************
   // Disabling the port drops any partial word; a slave with no data sends zeros
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         busy_reg <= 1'b0;
         bit_cnt_reg <= 5'd0;
         div_reg <= 3'h0;
         sclk_reg <= 1'b0;
         tx_sh_reg <= 16'h0000;
         rx_sh_reg <= 16'h0000;
      end else if (!en_reg) begin // see R12
         busy_reg <= 1'b0;
         bit_cnt_reg <= 5'd0;
         div_reg <= 3'h0;
         sclk_reg <= 1'b0;
         tx_sh_reg <= 16'h0000;
      end else begin
         if (mstr_reg && busy_reg) begin
            if (m_tick) begin
               div_reg <= 3'h0;
               sclk_reg <= ~sclk_reg;
            end else begin
               div_reg <= div_reg + 3'h1;
            end
         end
         if (s_act || mstr_reg) begin
            if (lead_c && !smp_eff) begin
               rx_sh_reg <= {rx_sh_reg[14:0], sdi_s};
            end
            if (trail_c) begin
               if (smp_eff) begin
                  rx_sh_reg <= {rx_sh_reg[14:0], sdi_s};
               end
               if (done_c) begin
                  bit_cnt_reg <= 5'd0;
                  busy_reg <= 1'b0;
                  tx_sh_reg <= 16'h0000;
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + 5'd1;
                  tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
               end
            end
         end else begin
            bit_cnt_reg <= 5'd0; // Select released mid-word restarts the frame
         end
         if (load_c) begin
            tx_sh_reg <= tx_q;
            busy_reg <= 1'b1;
            div_reg <= 3'h0;
            sclk_reg <= 1'b0;
            bit_cnt_reg <= 5'd0;
         end
      end
   end

   // ****************************************
   // Pins
   // ****************************************
   // Clock disable only releases the pin; the divider keeps pacing the transfer
   assign sclk_o = sclk_reg;
   assign sclk_oe_o = en_reg && mstr_reg && !ckdis_reg; // see R10, R12
   assign sdo_o = width_reg ? tx_sh_reg[15] : tx_sh_reg[7]; // see R11
   assign sdo_oe_o = en_reg && !dodis_reg && (mstr_reg || !ss_s); // see R12

   // ****************************************
   // Buffer interrupt selector
   // ****************************************
   reg lvl_c;
   reg pulse_c;

   // Level conditions fire on their rising edge, event conditions directly
   always @* begin
      lvl_c = 1'b0;
      pulse_c = 1'b0;
      case (sel_reg)
         `SPB_SEL_TXFULL: lvl_c = tx_full; // see R2
         `SPB_SEL_TXEMPTY: pulse_c = load_c && (tx_next == 3'h0); // see R3
         `SPB_SEL_DONE: pulse_c = done_c; // see R4
         `SPB_SEL_TXONE: pulse_c = load_c && (tx_next == (depth_c - 3'h1)); // see R5
         `SPB_SEL_RXFULL: lvl_c = rx_full; // see R6
         `SPB_SEL_RX3Q: lvl_c = (rx_cnt_reg >= `SPB_RX_3Q); // see R7
         `SPB_SEL_RXAVAIL: lvl_c = !rx_empty; // see R8
         `SPB_SEL_RXREAD: pulse_c = rx_pop && (rx_next == 3'h0); // see R9
         default: lvl_c = 1'b0;
      endcase
   end

   // Outside enhanced mode every received word raises the request
   wire buf_req = enh_reg ? (pulse_c || (lvl_c && !lvl_prev_reg)) : rx_push; // see R1, R14

   // ****************************************
   // Control and interrupt registers
   // ****************************************
   // Hardware set wins over a software clear in the same cycle
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         en_reg <= 1'b0;
         enh_reg <= 1'b0;
         sel_reg <= 3'h0;
         ovf_reg <= 1'b0;
         ckdis_reg <= 1'b0;
         dodis_reg <= 1'b0;
         width_reg <= 1'b0;
         smp_reg <= 1'b0;
         mstr_reg <= 1'b0;
         irqs_reg <= `SPB_RESET_IRQ;
         irqm_reg <= `SPB_RESET_IRQ;
         lvl_prev_reg <= 1'b0;
      end else begin
         lvl_prev_reg <= lvl_c;
         if (wr_stat) begin
            en_reg <= reg_wdata_i[`SPB_ST_EN];
            enh_reg <= reg_wdata_i[`SPB_ST_ENH];
            sel_reg <= reg_wdata_i[`SPB_ST_SEL_HI:`SPB_ST_SEL_LO];
         end
         if (ovf_set) begin
            ovf_reg <= 1'b1; // see R13
         end else if (wr_stat && !reg_wdata_i[`SPB_ST_OVF]) begin
            ovf_reg <= 1'b0;
         end
         if (wr_con1) begin
            ckdis_reg <= reg_wdata_i[`SPB_C1_CKDIS];
            dodis_reg <= reg_wdata_i[`SPB_C1_DODIS];
            width_reg <= reg_wdata_i[`SPB_C1_WIDTH];
            smp_reg <= reg_wdata_i[`SPB_C1_SMP];
            mstr_reg <= reg_wdata_i[`SPB_C1_MSTR];
         end
         if (wr_irqm) begin
            irqm_reg <= reg_wdata_i[1:0];
         end
         irqs_reg <= (irqs_reg & ~(wr_irqs ? reg_wdata_i[1:0] : 2'b00)) | {ovf_set, buf_req}; // see R14
      end
   end

   assign irq_o = |(irqs_reg & irqm_reg);

   // ****************************************
   // Read port
   // ****************************************
   wire [15:0] stat_word = {en_reg, enh_reg, 6'h00, !busy_reg, ovf_reg, rx_empty, sel_reg, tx_full, rx_full};
   wire [15:0] con1_word = {3'h0, ckdis_reg, dodis_reg, width_reg, smp_reg, 3'h0, mstr_reg, 5'h00};

   // Read data stand one cycle after the strobe; data reads take the FIFO output register
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= `SPB_RESET_WORD;
         data_sel_reg <= 1'b0;
      end else begin
         data_sel_reg <= rd_data;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `SPB_ADDR_STAT: rdata_reg <= stat_word;
               `SPB_ADDR_CON1: rdata_reg <= con1_word;
               `SPB_ADDR_IRQS: rdata_reg <= {14'h0000, irqs_reg};
               `SPB_ADDR_IRQM: rdata_reg <= {14'h0000, irqm_reg};
               default: rdata_reg <= 16'h0000;
            endcase
         end else begin
            rdata_reg <= 16'h0000;
         end
      end
   end

   assign reg_rdata_o = data_sel_reg ? rx_q : rdata_reg;
endmodule

// file: spb_core_tb.sv
// Register-level testbench of the serial port core in master mode.
// Assumes spb_peer on the link and the checker bound to spb_core.
`timescale 1ns/1ps
`include "spb_map.vh"
`define SPB_CHK(name, exp, act) begin check_count = check_count + 1; if ((act) !== (exp)) begin \
   fail_count = fail_count + 1; $display("BAD %s expected %h seen %h", name, exp, act); end end
module spb_core_tb;
   reg clock_i = 1'b0;
   reg rst_i = 1'b1;
   reg [3:0] reg_addr_i = 4'h0;
   reg [15:0] reg_wdata_i = 16'h0000;
   reg reg_wr_i = 1'b0;
   reg reg_rd_i = 1'b0;
   reg w16 = 1'b0;
   reg [15:0] got;
   wire [15:0] reg_rdata_o, peer_rx;
   wire [7:0] peer_words;
   wire irq_o, sclk_o, sclk_oe_o, sdo_o, sdo_oe_o, sdi_w;
   integer fail_count = 0;
   integer check_count = 0;
   integer i, c, n, nexp;
   spb_core uut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .sclk_i(1'b0),
      .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sdi_i(sdi_w), .ss_n_i(1'b1));
   spb_peer peer (.rst_i(rst_i), .sclk_i(sclk_o), .sdo_i(sdo_o), .width16_i(w16), .sdi_o(sdi_w),
      .rx_word_o(peer_rx), .words_o(peer_words));
   // ****************
   // Clock and bus tasks
   // ****************
   initial begin
      forever #50 clock_i = ~clock_i;
   end
   task close_out;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // Settle a step past the taking edge so flags are read after they land
   task wr(input [3:0] a, input [15:0] d);
      begin
         @(posedge clock_i);
         reg_addr_i <= a;
         reg_wdata_i <= d;
         reg_wr_i <= 1'b1;
         @(posedge clock_i);
         reg_wr_i <= 1'b0;
         #1;
      end
   endtask
   task rd(input [3:0] a);
      begin
         @(posedge clock_i);
         reg_addr_i <= a;
         reg_rd_i <= 1'b1;
         @(posedge clock_i);
         reg_rd_i <= 1'b0;
         #1;
         got = reg_rdata_o;
      end
   endtask
   // Back-to-back pushes, so the transmit side fills before the first word ends
   task burst(input integer cnt);
      begin
         for (i = 0; i < cnt; i = i + 1) begin
            @(posedge clock_i);
            reg_addr_i <= `SPB_ADDR_DATA;
            reg_wdata_i <= 16'hff10 + i;
            reg_wr_i <= 1'b1;
         end
         @(posedge clock_i);
         reg_wr_i <= 1'b0;
      end
   endtask
   // Six cycles cover the last trail edge and the receive push after the last lead edge
   task wait_words(input integer target);
      integer k;
      begin
         k = 0;
         while (peer_words != target[7:0] && k < 3000) begin
            @(posedge clock_i);
            k = k + 1;
         end
         if (k == 3000) begin
            fail_count = fail_count + 1;
            $display("BAD link words expected %0d seen %0d", target, peer_words);
            close_out;
         end else begin
            repeat (6) @(posedge clock_i);
         end
      end
   endtask
   // ****************
   // Main sequence
   // ****************
   initial begin
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      nexp = 0;
      rd(`SPB_ADDR_CON1);
      `SPB_CHK("con1 reset", 16'h0000, got)
      rd(4'hf);
      `SPB_CHK("unmapped", 16'h0000, got)
      wr(`SPB_ADDR_CON1, 16'h1820);
      wr(`SPB_ADDR_STAT, 16'hc004);
      wr(`SPB_ADDR_IRQM, 16'h0003);
      rd(`SPB_ADDR_CON1);
      `SPB_CHK("con1", 16'h1820, got)
      `SPB_CHK("clk oe disabled", 1'b0, sclk_oe_o)
      `SPB_CHK("sdo oe disabled", 1'b0, sdo_oe_o)
      wr(`SPB_ADDR_CON1, 16'h0020);
      `SPB_CHK("clk oe", 1'b1, sclk_oe_o)
      `SPB_CHK("sdo oe", 1'b1, sdo_oe_o)
      // Each selector code over one run of five words; the fifth overflows a full receive side
      for (c = 7; c >= 0; c = c - 1) begin
         wr(`SPB_ADDR_STAT, 16'hc000 | ({13'h0000, c[2:0]} << 2));
         wr(`SPB_ADDR_IRQS, 16'h0003);
         burst(5);
         nexp = nexp + 5;
         wait_words(nexp);
         rd(`SPB_ADDR_IRQS);
         `SPB_CHK("irq status", (c != 0) ? 16'h0003 : 16'h0002, got)
         `SPB_CHK("irq line", 1'b1, irq_o)
         rd(`SPB_ADDR_STAT);
         `SPB_CHK("status", 16'hc0c1 | ({13'h0000, c[2:0]} << 2), got)
         `SPB_CHK("peer rx", 16'h0014, peer_rx)
         for (n = 0; n < 4; n = n + 1) begin
            rd(`SPB_ADDR_DATA);
            `SPB_CHK("rx word", 16'h0040 + nexp - 5 + n, got)
         end
         if (c == 0) begin
            rd(`SPB_ADDR_IRQS);
            `SPB_CHK("irq empty", 16'h0003, got)
         end
      end
      // Legacy buffer: selector ignored, every received word requests
      wr(`SPB_ADDR_STAT, 16'h8000);
      wr(`SPB_ADDR_IRQS, 16'h0003);
      wr(`SPB_ADDR_DATA, 16'h0077);
      nexp = nexp + 1;
      wait_words(nexp);
      rd(`SPB_ADDR_IRQS);
      `SPB_CHK("legacy irq", 16'h0001, got)
      wr(`SPB_ADDR_IRQM, 16'h0000);
      `SPB_CHK("irq masked", 1'b0, irq_o)
      wr(`SPB_ADDR_IRQM, 16'h0003);
      `SPB_CHK("irq unmasked", 1'b1, irq_o)
      wr(`SPB_ADDR_IRQS, 16'h0001);
      `SPB_CHK("irq cleared", 1'b0, irq_o)
      rd(`SPB_ADDR_DATA);
      `SPB_CHK("legacy rx", 16'h0040 + nexp - 1, got)
      // Word width, input sampled at the end of each bit
      wr(`SPB_ADDR_CON1, 16'h0620);
      w16 <= 1'b1;
      wr(`SPB_ADDR_DATA, 16'ha55a);
      nexp = nexp + 1;
      wait_words(nexp);
      `SPB_CHK("peer rx 16", 16'ha55a, peer_rx)
      rd(`SPB_ADDR_DATA);
      `SPB_CHK("rx 16", 16'hc340 + nexp - 1, got)
      wr(`SPB_ADDR_STAT, 16'h0000);
      `SPB_CHK("off clk oe", 1'b0, sclk_oe_o)
      close_out;
   end
endmodule

// file: spb_map.vh
// Register offsets, field positions, reset values and timing counts of the serial port block.
// Assumes the includer keeps word-indexed register addresses on a plain strobe port.
//
// Function
// R1: The three-bit buffer interrupt selector at bits 4 to 2 is obeyed only in enhanced buffer mode.
// R2: Selector 111 requests an interrupt when the transmit buffer becomes full.
// R3: Selector 110 requests an interrupt when a word enters the shifter and leaves the transmit FIFO empty.
// R4: Selector 101 requests an interrupt when the last bit has left the shifter and the transfer is done.
// R5: Selector 100 requests an interrupt when a word enters the shifter and leaves one free transmit slot.
// R6: Selector 011 requests an interrupt when the receive buffer becomes full.
// R7: Selector 010 requests an interrupt when the receive buffer is three quarters full or more.
// R8: Selector 001 requests an interrupt while at least one received word waits in the buffer.
// R9: Selector 000 requests an interrupt when software reads the last received word and the buffer empties.
// R10: In master mode the clock-disable bit 12 releases the clock pin and stops the clock output; here only sclk_oe_o drops and sclk_o keeps toggling.
// R11: Width-select bit 10 makes each transfer 16 bits when set and 8 bits when clear.
// R12: The port enable bit turns the port on and hands its pins to it, and clearing it turns it off.
// R13: A word completed while the receive buffer is still full is dropped and sets the overflow flag.
// R14: The selected condition reaches the interrupt logic as one request each time it becomes true.
`ifndef SPB_MAP_VH
`define SPB_MAP_VH

// ****************************************
// Register word addresses
// ****************************************
`define SPB_ADDR_STAT 4'h0
`define SPB_ADDR_CON1 4'h1
`define SPB_ADDR_DATA 4'h2
`define SPB_ADDR_IRQS 4'h3
`define SPB_ADDR_IRQM 4'h4

// ****************************************
// Status and control word fields
// ****************************************
`define SPB_ST_EN 15
`define SPB_ST_ENH 14
`define SPB_ST_SRE 7
`define SPB_ST_OVF 6
`define SPB_ST_RXE 5
`define SPB_ST_SEL_HI 4
`define SPB_ST_SEL_LO 2
`define SPB_ST_TXF 1
`define SPB_ST_RXF 0

// ****************************************
// Control one fields
// ****************************************
`define SPB_C1_CKDIS 12
`define SPB_C1_DODIS 11
`define SPB_C1_WIDTH 10
`define SPB_C1_SMP 9
`define SPB_C1_MSTR 5

// ****************************************
// Interrupt status bits, reset values
// ****************************************
`define SPB_IRQ_BUF 0
`define SPB_IRQ_OVF 1
`define SPB_RESET_WORD 16'h0000
`define SPB_RESET_IRQ 2'h0

// ****************************************
// Buffer depths and selector codes
// ****************************************
`define SPB_DEPTH_ENH 3'h4
`define SPB_DEPTH_LEG 3'h1
`define SPB_RX_3Q 3'h3
`define SPB_SEL_TXFULL 3'h7
`define SPB_SEL_TXEMPTY 3'h6
`define SPB_SEL_DONE 3'h5
`define SPB_SEL_TXONE 3'h4
`define SPB_SEL_RXFULL 3'h3
`define SPB_SEL_RX3Q 3'h2
`define SPB_SEL_RXAVAIL 3'h1
`define SPB_SEL_RXREAD 3'h0

// ****************************************
// Timing
// ****************************************
`define SPB_CLK_NS 100
`define SPB_SCLK_HALF_NS 400
`define SPB_SCLK_HALF (`SPB_SCLK_HALF_NS / `SPB_CLK_NS)

`endif

// file: spb_mem.v
// Small word store for one FIFO of the serial port.
// Assumes the owner keeps the pointers; read data come out of a register.
`timescale 1ns/1ps
module spb_mem (
   input wire clock_i,
   input wire rst_i,
   input wire wr_en_i,
   input wire [1:0] wr_addr_i,
   input wire [15:0] wr_data_i,
   input wire [1:0] rd_addr_i,
   output reg [15:0] rd_data_o
);
   reg [15:0] mem [0:3];

   // Array is not reset; only transmit loads wait for a valid count, data reads return it even with the receive side empty
   always @(posedge clock_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   // Registered read port
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o <= 16'h0000;
      end else begin
         rd_data_o <= mem[rd_addr_i];
      end
   end
endmodule

// file: spb_peer.sv
// Behavioural mode 0 serial slave standing on the far side of the link.
// Assumes the core is master, drives the link clock idle low and sends MSB first.
`timescale 1ns/1ps
module spb_peer (
   input wire rst_i,
   input wire sclk_i,
   input wire sdo_i,
   input wire width16_i,
   output wire sdi_o,
   output reg [15:0] rx_word_o,
   output reg [7:0] words_o
);
   reg [15:0] shift_reg;
   reg [3:0] bit_reg;
   reg [3:0] ptr_reg;
   reg [7:0] idx_reg;
   wire [3:0] top = width16_i ? 4'hf : 4'h7;
   // Word index moves on the trail edge, so the last bit holds until the trail sample
   wire [15:0] send = {8'hc3, 8'h40 + idx_reg};
   // Pointer moves on the trail edge only, so the bit is steady at each lead edge
   assign sdi_o = send[top - ptr_reg];
   // Capture on the lead edge, MSB first
   always @(posedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_reg <= 16'h0000;
         bit_reg <= 4'h0;
         words_o <= 8'h00;
         rx_word_o <= 16'h0000;
      end else begin
         shift_reg <= {shift_reg[14:0], sdo_i};
         if (bit_reg == top) begin
            rx_word_o <= width16_i ? {shift_reg[14:0], sdo_i} : {8'h00, shift_reg[6:0], sdo_i};
            bit_reg <= 4'h0;
            words_o <= words_o + 8'h01;
         end else
            bit_reg <= bit_reg + 4'h1;
      end
   end
   // Next bit goes out on the trail edge
   always @(negedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         ptr_reg <= 4'h0;
         idx_reg <= 8'h00;
      end else begin
         ptr_reg <= bit_reg;
         idx_reg <= words_o;
      end
   end
endmodule
